// ### core/bhr_host_regs.sv
// Banked host register window with setup word loading
`timescale 1ns/1ps
`default_nettype none
module bhr_host_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] host_addr,
    input wire logic [3:0] byte_lane_enables_n,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [31:0] host_data_in,
    output logic [31:0] host_data_out,
    output logic host_data_oe,
    input wire logic wide_bus_variant,
    output logic eeprom_read_req,
    output logic [5:0] eeprom_read_addr,
    input wire logic eeprom_word_valid,
    input wire logic [15:0] eeprom_setup_word,
    input wire logic [15:0] memory_selftest_info,
    output logic core_clk_is_25m,
    output logic host_bus_is_16,
    output logic host_bus_is_32,
    output logic setup_loaded
);
    // Fetch of the setup word after reset
    bhr_pkg::bhr_fetch_t fetch_q;
    bhr_pkg::bhr_fetch_t fetch_d;
    logic setup_take;
    logic variant32_q;
    logic clk25_q;
    logic bus16_q;
    logic [15:0] power_mgmt_control_reg_q;
    logic [15:0] power_mgmt_control_reg_d;

    // Host access decode
    logic host_sel;
    logic rd_act;
    logic wr_act;
    logic wr_seen_q;
    logic wr_go;
    logic [1:0] dword;
    logic [3:0] lanes_n8;
    logic [3:0] lanes;
    logic [3:0] wr_lanes;
    logic [31:0] wdata;
    logic [15:0] bank_sel;
    logic [4:0] bank;
    logic [31:0] rd_dword;
    logic [31:0] rd_fixed;
    logic [31:0] rd_lane;
    logic [31:0] store_rd [bhr_pkg::NUM_STORE];
    logic [31:0] rdata_q;
    logic oe_q;

    assign eeprom_read_req = (fetch_q == bhr_pkg::FETCH_ASK);
    assign eeprom_read_addr = bhr_pkg::EEPROM_SETUP_ADDR;
    assign setup_take = (fetch_q == bhr_pkg::FETCH_WAIT) && eeprom_word_valid;
    assign setup_loaded = (fetch_q == bhr_pkg::FETCH_DONE);

    always_comb begin
        fetch_d = fetch_q;
        unique case (fetch_q)
            bhr_pkg::FETCH_ASK: begin
                fetch_d = bhr_pkg::FETCH_WAIT;
            end
            bhr_pkg::FETCH_WAIT: begin
                if (eeprom_word_valid) begin
                    fetch_d = bhr_pkg::FETCH_DONE;
                end
            end
            bhr_pkg::FETCH_DONE: begin
                fetch_d = bhr_pkg::FETCH_DONE;
            end
        endcase
    end

    // Power control word takes its setup bits on load
    always_comb begin
        power_mgmt_control_reg_d = power_mgmt_control_reg_q;
        if (setup_take) begin
            power_mgmt_control_reg_d[bhr_pkg::POWER_MGMT_CONTROL_REG_BUS16_BIT] = eeprom_setup_word[bhr_pkg::SETUP_BUS16_BIT];
            power_mgmt_control_reg_d[bhr_pkg::POWER_MGMT_CONTROL_REG_D1_SUP_BIT] = eeprom_setup_word[bhr_pkg::SETUP_D1_SUP_BIT];
            power_mgmt_control_reg_d[bhr_pkg::POWER_MGMT_CONTROL_REG_D2_SUP_BIT] = eeprom_setup_word[bhr_pkg::SETUP_D2_SUP_BIT];
            power_mgmt_control_reg_d[bhr_pkg::POWER_MGMT_CONTROL_REG_PME_D1_BIT] = eeprom_setup_word[bhr_pkg::SETUP_PME_D1_BIT];
            power_mgmt_control_reg_d[bhr_pkg::POWER_MGMT_CONTROL_REG_PME_D2_BIT] = eeprom_setup_word[bhr_pkg::SETUP_PME_D2_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_q <= bhr_pkg::FETCH_ASK;
            power_mgmt_control_reg_q <= bhr_pkg::POWER_MGMT_CONTROL_REG_RESET;
        end else begin
            fetch_q <= fetch_d;
            power_mgmt_control_reg_q <= power_mgmt_control_reg_d;
        end
    end

    // Strap caught in the first cycle after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            variant32_q <= 1'b0;
        end else if (fetch_q == bhr_pkg::FETCH_ASK) begin
            variant32_q <= wide_bus_variant;
        end
    end

    // Fast core clock until the setup word says otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk25_q <= 1'b0;
            bus16_q <= 1'b0;
        end else if (setup_take) begin
            clk25_q <= eeprom_setup_word[bhr_pkg::SETUP_CLK_RATE_BIT];
            bus16_q <= eeprom_setup_word[bhr_pkg::SETUP_BUS16_BIT];
        end
    end

    assign core_clk_is_25m = clk25_q;
    assign host_bus_is_32 = variant32_q;
    assign host_bus_is_16 = bus16_q && !variant32_q;

    // Bus strobes; a write acts once per assertion
    assign host_sel = !host_cs_n;
    assign rd_act = host_sel && !host_rd_n;
    assign wr_act = host_sel && !host_wr_n;
    assign wr_go = wr_act && !wr_seen_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_seen_q <= 1'b0;
        end else begin
            wr_seen_q <= wr_act;
        end
    end

    // Lanes and data folded onto one aligned 32-bit word
    assign dword = host_addr[3:2];
    assign lanes_n8 = (host_addr[1:0] == 2'h0) ? 4'b0001 :
                      (host_addr[1:0] == 2'h1) ? 4'b0010 :
                      (host_addr[1:0] == 2'h2) ? 4'b0100 : 4'b1000;
    assign lanes = host_bus_is_32 ? ~byte_lane_enables_n :
                   host_bus_is_16 ? (host_addr[1] ? {~byte_lane_enables_n[1:0], 2'b00}
                                                  : {2'b00, ~byte_lane_enables_n[1:0]}) :
                   (byte_lane_enables_n[0] ? 4'b0000 : lanes_n8);
    assign wdata = host_bus_is_32 ? host_data_in :
                   host_bus_is_16 ? {2{host_data_in[15:0]}} : {4{host_data_in[7:0]}};
    assign wr_lanes = wr_go ? lanes : 4'b0000;

    // Shared bank select word, present in every bank
    bhr_word_reg #(
        .RESET_VALUE(bhr_pkg::BANK_SEL_RESET)
    ) u_bank_sel (
        .clk(clk),
        .rst_n(rst_n),
        .wr_lane((dword == bhr_pkg::OFF_BANK_SEL[3:2]) ? wr_lanes[3:2] : 2'b00),
        .wr_data(wdata[31:16]),
        .value(bank_sel)
    );
    assign bank = bank_sel[4:0];

    // Plain storage words; unmatched locations are not written
    genvar gi;
    generate
        for (gi = 0; gi < bhr_pkg::NUM_STORE; gi++) begin : g_store
            logic hit;
            logic hi;
            logic [15:0] val;
            assign hit = (bank == bhr_pkg::STORE_BANK[gi]) &&
                         (dword == bhr_pkg::STORE_OFF[gi][3:2]);
            assign hi = bhr_pkg::STORE_OFF[gi][1];
            bhr_word_reg #(
                .RESET_VALUE(bhr_pkg::STORE_RESET)
            ) u_word (
                .clk(clk),
                .rst_n(rst_n),
                .wr_lane(!hit ? 2'b00 : (hi ? wr_lanes[3:2] : wr_lanes[1:0])),
                .wr_data(hi ? wdata[31:16] : wdata[15:0]),
                .value(val)
            );
            assign store_rd[gi] = !hit ? 32'h0000_0000 :
                                  (hi ? {val, 16'h0000} : {16'h0000, val});
        end
    endgenerate

    // Read-only words and the shared bank select
    assign rd_fixed =
        ((dword == bhr_pkg::OFF_BANK_SEL[3:2]) ? {bank_sel, 16'h0000} : 32'h0000_0000) |
        ((bank == bhr_pkg::BANK_SELFTEST) && (dword == bhr_pkg::OFF_SELFTEST[3:2]) ?
            {16'h0000, memory_selftest_info} : 32'h0000_0000) |
        ((bank == bhr_pkg::BANK_POWER_MGMT_CONTROL_REG) && (dword == bhr_pkg::OFF_POWER_MGMT_CONTROL_REG[3:2]) ?
            {16'h0000, power_mgmt_control_reg_q} : 32'h0000_0000);

    // Reserved places contribute nothing, so they read zero
    always_comb begin
        rd_dword = rd_fixed;
        for (int i = 0; i < bhr_pkg::NUM_STORE; i++) begin
            rd_dword = rd_dword | store_rd[i];
        end
    end

    assign rd_lane = host_bus_is_32 ? rd_dword :
                     host_bus_is_16 ? (host_addr[1] ? {16'h0000, rd_dword[31:16]}
                                                    : {16'h0000, rd_dword[15:0]}) :
                     {24'h000000, rd_dword[8 * host_addr[1:0] +: 8]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            oe_q <= 1'b0;
        end else begin
            rdata_q <= rd_act ? rd_lane : 32'h0000_0000;
            oe_q <= rd_act;
        end
    end

    assign host_data_out = rdata_q;
    assign host_data_oe = oe_q;

    chk_fast_after_reset: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fetch_q != bhr_pkg::FETCH_DONE) |-> !core_clk_is_25m)
        else $error("Core left the fast clock before the setup word arrived");

    chk_clock_rate_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        setup_take |=> (core_clk_is_25m == $past(eeprom_setup_word[1]))
                       ##1 $stable(core_clk_is_25m))
        else $error("Clock rate select does not follow the setup word");

    chk_bus_width_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        (setup_take && !variant32_q) |=> (host_bus_is_16 == $past(eeprom_setup_word[0])))
        else $error("Host bus width does not follow the setup bit");

    chk_power_mgmt_control_reg_bit0_copy: assert property (
        @(posedge clk) disable iff (!rst_n)
        setup_take |=> (power_mgmt_control_reg_q[0] == $past(eeprom_setup_word[0])) && setup_loaded)
        else $error("Power control bit 0 missed the bus width bit");

    chk_wide_bus_fixed: assert property (
        @(posedge clk) disable iff (!rst_n)
        variant32_q |-> (host_bus_is_32 && !host_bus_is_16))
        else $error("Wide variant did not keep the 32-bit bus");

    chk_fetch_word_six: assert property (
        @(posedge clk) disable iff (!rst_n)
        eeprom_read_req |-> (eeprom_read_addr == 6'h06) ##1 !eeprom_read_req)
        else $error("Setup fetch used the wrong word or repeated");

    chk_bank_sel_visible: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_act && host_bus_is_32 && dword == 2'h3 && !wr_go)
            |=> (host_data_out[31:16] == bank_sel) && host_data_oe)
        else $error("Bank select not visible at the top word");

    chk_bank_next_access: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_go && host_bus_is_32 && dword == 2'h3 && byte_lane_enables_n == 4'h0)
            |=> (bank_sel == $past(host_data_in[31:16])))
        else $error("Bank select write not in force for the next access");

    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_act && host_bus_is_32 && dword != 2'h3 && bank_sel[4:3] == 2'b01)
            |=> (host_data_out == 32'h0000_0000))
        else $error("Reserved location did not read zero");

    chk_read_enable: assert property (
        @(posedge clk) disable iff (!rst_n)
        host_data_oe == $past(rd_act))
        else $error("Data drive does not match the read strobe");

    chk_idle_data_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rd_act |=> (host_data_out == 32'h0000_0000) && !host_data_oe)
        else $error("Data bus not idle after a cycle without a read");

    chk_write_once: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_act && wr_seen_q) |-> (wr_lanes == 4'h0))
        else $error("Held write strobe wrote a second time");

    chk_wide_lanes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_go && host_bus_is_32) |-> (wr_lanes == ~byte_lane_enables_n))
        else $error("Wide bus lanes do not follow the lane enables");

    chk_half_lanes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_go && host_bus_is_16)
            |-> (host_addr[1] ? (wr_lanes[1:0] == 2'h0) : (wr_lanes[3:2] == 2'h0)))
        else $error("Half-word write reached the wrong half");

    chk_byte_lane_one: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_go && !host_bus_is_32 && !host_bus_is_16 && !byte_lane_enables_n[0])
            |-> $onehot(wr_lanes))
        else $error("Byte write did not hit exactly one lane");

    chk_narrow_read_pad: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_act && !host_bus_is_32) |=> (host_data_out[31:16] == 16'h0000))
        else $error("Narrow read left data in the upper half");

    chk_bank_sel_kept: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(wr_go && (dword == 2'h3)) |=> $stable(bank_sel))
        else $error("Bank select changed without a write to it");

    chk_power_mgmt_control_reg_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !setup_take |=> $stable(power_mgmt_control_reg_q))
        else $error("Power control word changed outside setup loading");

    chk_clock_held: assert property (
        @(posedge clk) disable iff (!rst_n)
        setup_loaded |=> $stable(core_clk_is_25m))
        else $error("Clock rate changed after setup loading");

    chk_width_held: assert property (
        @(posedge clk) disable iff (!rst_n)
        setup_loaded |=> $stable(host_bus_is_16))
        else $error("Bus width changed after setup loading");

    chk_strap_held: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fetch_q != bhr_pkg::FETCH_ASK) |=> $stable(host_bus_is_32))
        else $error("Wide variant strap changed after capture");

    chk_fetch_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        setup_loaded |-> !eeprom_read_req)
        else $error("Setup word requested again after loading");

    chk_selftest_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_act && (host_bus_is_32 || host_bus_is_16) &&
            (host_addr == bhr_pkg::OFF_SELFTEST) && (bank == bhr_pkg::BANK_SELFTEST))
            |=> (host_data_out[15:0] == $past(memory_selftest_info)))
        else $error("Self-test word not returned at its location");

    chk_power_mgmt_control_reg_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_act && (host_bus_is_32 || host_bus_is_16) &&
            (host_addr == bhr_pkg::OFF_POWER_MGMT_CONTROL_REG) && (bank == bhr_pkg::BANK_POWER_MGMT_CONTROL_REG))
            |=> (host_data_out[15:0] == $past(power_mgmt_control_reg_q)))
        else $error("Power control word not returned at its location");
endmodule
`default_nettype wire

// ### core/bhr_pkg.sv
// Constants shared by the banked host register access block
// Operation
// - Core runs 125 MHz, or 25 MHz when set
// - Start at 125 MHz until setup asks less
// - Setup width bit picks 16 or 8 bits
// - Copy width bit into power control bit 0
// - Wide variant ignores width bit, stays 32
// - Sixteen byte locations, registers spread over banks
// - Bank select at 0xE-0xF in every bank
// - Byte lane enables pick 8/16/32 bit access
// - All control and data go through I/O registers
// - Host reaches registers over generic parallel bus
// - Setup word fetched from serial ROM word 6
package bhr_pkg;
    localparam int NUM_STORE = 18;

    // Byte offsets inside the 16-location window
    localparam logic [3:0] OFF_W0 = 4'h0;
    localparam logic [3:0] OFF_W1 = 4'h2;
    localparam logic [3:0] OFF_W2 = 4'h4;
    localparam logic [3:0] OFF_POWER_MGMT_CONTROL_REG = 4'h8;
    localparam logic [3:0] OFF_BANK_SEL = 4'he;

    localparam logic [4:0] BANK_CFG = 5'h00;
    localparam logic [4:0] BANK_STATION = 5'h02;
    localparam logic [4:0] BANK_INTERNAL = 5'h03;
    localparam logic [4:0] BANK_WAKE0 = 5'h04;
    localparam logic [4:0] BANK_WAKE1 = 5'h05;
    localparam logic [4:0] BANK_WAKE2 = 5'h06;
    localparam logic [4:0] BANK_WAKE3 = 5'h07;

    // Plain read/write storage words: bank and byte offset of each
    // 0 io_base_address, 1..3 station_address low/mid/high,
    // 4 internal_bus_control, 5 serial_rom_control,
    // 6..17 wake pattern 0..3 crc low, crc high, byte mask0
    localparam logic [4:0] STORE_BANK [NUM_STORE] = '{
        BANK_CFG, BANK_STATION, BANK_STATION, BANK_STATION,
        BANK_INTERNAL, BANK_INTERNAL,
        BANK_WAKE0, BANK_WAKE0, BANK_WAKE0,
        BANK_WAKE1, BANK_WAKE1, BANK_WAKE1,
        BANK_WAKE2, BANK_WAKE2, BANK_WAKE2,
        BANK_WAKE3, BANK_WAKE3, BANK_WAKE3};
    localparam logic [3:0] STORE_OFF [NUM_STORE] = '{
        OFF_W0, OFF_W0, OFF_W1, OFF_W2,
        OFF_W0, OFF_W1,
        OFF_W0, OFF_W1, OFF_W2,
        OFF_W0, OFF_W1, OFF_W2,
        OFF_W0, OFF_W1, OFF_W2,
        OFF_W0, OFF_W1, OFF_W2};
    localparam logic [15:0] STORE_RESET = 16'h0000;

    // Read-only self-test word and power control word
    localparam logic [4:0] BANK_SELFTEST = BANK_INTERNAL;
    localparam logic [3:0] OFF_SELFTEST = OFF_W2;
    localparam logic [4:0] BANK_POWER_MGMT_CONTROL_REG = BANK_INTERNAL;

    localparam logic [15:0] BANK_SEL_RESET = 16'h0000;
    localparam logic [15:0] POWER_MGMT_CONTROL_REG_RESET = 16'h0000;

    // Setup word layout and where its bits land in the power control word
    localparam int SETUP_BUS16_BIT = 0;
    localparam int SETUP_CLK_RATE_BIT = 1;
    localparam int SETUP_D1_SUP_BIT = 9;
    localparam int SETUP_D2_SUP_BIT = 10;
    localparam int SETUP_PME_D1_BIT = 11;
    localparam int SETUP_PME_D2_BIT = 12;
    localparam int POWER_MGMT_CONTROL_REG_BUS16_BIT = 0;
    localparam int POWER_MGMT_CONTROL_REG_D1_SUP_BIT = 9;
    localparam int POWER_MGMT_CONTROL_REG_D2_SUP_BIT = 10;
    localparam int POWER_MGMT_CONTROL_REG_PME_D1_BIT = 12;
    localparam int POWER_MGMT_CONTROL_REG_PME_D2_BIT = 13;

    localparam logic [5:0] EEPROM_SETUP_ADDR = 6'h06;

    localparam int CORE_FAST_MHZ = 125;
    localparam int CORE_SLOW_MHZ = 25;

    typedef enum logic [1:0] {FETCH_ASK, FETCH_WAIT, FETCH_DONE} bhr_fetch_t;
endpackage

// ### core/bhr_word_reg.sv
// One 16-bit register word with two byte-lane write enables
`timescale 1ns/1ps
`default_nettype none
module bhr_word_reg #(
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] wr_lane,
    input wire logic [15:0] wr_data,
    output logic [15:0] value
);
    logic [15:0] value_q;
    logic [15:0] value_d;

    assign value_d[7:0] = wr_lane[0] ? wr_data[7:0] : value_q[7:0];
    assign value_d[15:8] = wr_lane[1] ? wr_data[15:8] : value_q[15:8];
    assign value = value_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RESET_VALUE;
        end else begin
            value_q <= value_d;
        end
    end
endmodule
`default_nettype wire

// ### verification/bhr_rom_model.sv
// Serial ROM reader model that answers the setup word request
`timescale 1ns/1ps
`default_nettype none
module bhr_rom_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic read_req,
    input wire logic [5:0] read_addr,
    input wire logic [15:0] setup,
    output logic word_valid,
    output logic [15:0] word_out
);
    logic busy_q;
    logic [2:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
            word_valid <= 1'b0;
        end else begin
            word_valid <= busy_q && (cnt_q == 3'h1);
            if (read_req && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q <= 3'h4;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
    // Only word 6 carries the setup bits; otherwise the inverted setup word
    assign word_out = (word_valid && read_addr == 6'h06) ? setup : ~setup;
endmodule
`default_nettype wire

// ### verification/tb_banked_host_register_access.sv
// Testbench for the banked host register window
`timescale 1ns/1ps
`default_nettype none
module tb_banked_host_register_access;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [3:0] be_n = 4'hf;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [31:0] din = 32'h0;
    logic strap = 1'b0;
    logic [15:0] rom_word = 16'h0;
    logic [31:0] host_data_out;
    logic host_data_oe, req, valid, clk25, bus16, bus32, loaded;
    logic [5:0] raddr;
    logic [15:0] word;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    bhr_host_regs i_bhr_host_regs (.clk(clk), .rst_n(rst_n), .host_addr(addr),
        .byte_lane_enables_n(be_n), .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
        .host_data_in(din), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .wide_bus_variant(strap), .eeprom_read_req(req), .eeprom_read_addr(raddr),
        .eeprom_word_valid(valid), .eeprom_setup_word(word),
        .memory_selftest_info(16'h5a3c), .core_clk_is_25m(clk25),
        .host_bus_is_16(bus16), .host_bus_is_32(bus32), .setup_loaded(loaded));

    bhr_rom_model i_bhr_rom_model (.clk(clk), .rst_n(rst_n), .read_req(req),
        .read_addr(raddr), .setup(rom_word), .word_valid(valid), .word_out(word));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic boot(input logic s, input logic [15:0] w);
        int n;
        @(posedge clk);
        rst_n <= 1'b0;
        strap <= s;
        rom_word <= w;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        #1;
        chk("rom address", {26'h0, raddr}, 32'h6);
        chk("clock before load", {31'h0, clk25}, 32'h0);
        n = 0;
        while (loaded !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk("setup loaded", {31'h0, loaded}, 32'h1);
    endtask

    task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        be_n <= be;
        din <= d;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        din <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, input logic [3:0] be, input string name,
                      input logic [31:0] exp);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        be_n <= be;
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        #1;
        chk(name, host_data_out, exp);
        chk("read enable", {31'h0, host_data_oe}, 32'h1);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        // 16-bit host bus, slow core, power bits set
        boot(1'b0, 16'h1e03);
        chk("slow core", {31'h0, clk25}, 32'h1);
        chk("bus 16", {30'h0, bus32, bus16}, 32'h1);
        wr(4'he, 4'b1100, 32'h3);
        rd(4'h8, 4'b1100, "power control", 32'h3601);
        rd(4'he, 4'b1100, "bank select", 32'h3);
        wr(4'h4, 4'b1100, 32'hffff);
        rd(4'h4, 4'b1100, "self test", 32'h5a3c);
        wr(4'he, 4'b1100, 32'h2);
        wr(4'h0, 4'b1100, 32'h1234);
        wr(4'h2, 4'b1110, 32'hbeef);
        rd(4'h2, 4'b1100, "low byte lane", 32'h00ef);
        rd(4'h0, 4'b1100, "station low", 32'h1234);
        wr(4'he, 4'b1100, 32'h4);
        rd(4'h0, 4'b1100, "other bank", 32'h0);
        wr(4'he, 4'b1100, 32'h1);
        wr(4'h0, 4'b1100, 32'h7777);
        rd(4'h0, 4'b1100, "reserved", 32'h0);
        wr(4'he, 4'b1100, 32'h2);
        rd(4'h0, 4'b1100, "station kept", 32'h1234);
        // Wide variant ignores the width bit
        boot(1'b1, 16'h0001);
        chk("fast core", {31'h0, clk25}, 32'h0);
        chk("bus 32", {30'h0, bus32, bus16}, 32'h2);
        wr(4'hc, 4'b0000, 32'h00020000);
        wr(4'h0, 4'b0000, 32'habcd1234);
        rd(4'h0, 4'b0000, "dword access", 32'habcd1234);
        rd(4'hc, 4'b0000, "bank dword", 32'h00020000);
        wr(4'hc, 4'b0000, 32'h00080000);
        wr(4'h4, 4'b0000, 32'h55aa55aa);
        rd(4'h4, 4'b0000, "reserved bank", 32'h0);
        // 8-bit host bus
        boot(1'b0, 16'h0000);
        chk("bus 8", {30'h0, bus32, bus16}, 32'h0);
        wr(4'he, 4'b1110, 32'h2);
        wr(4'h1, 4'b1110, 32'h5a);
        rd(4'h1, 4'b1110, "byte high", 32'h5a);
        rd(4'h0, 4'b1110, "byte low", 32'h0);
        wr(4'he, 4'b1110, 32'h3);
        rd(4'h8, 4'b1110, "power bit0", 32'h0);
        rd(4'he, 4'b1110, "bank byte", 32'h3);
        wrap_up();
    end
endmodule
`default_nettype wire
